// ### include/cod_pkg.sv
// Purpose: shared constants of the current output data and status block
// Assumes: counts are two's complement words, sign in bit 15
// Notes: image numbers are the gateway's register numbering
package cod_pkg;

    // gateway process images, one word per module
    localparam int IMG_WORDS = 4096;
    localparam int OUT_IMG_FIRST = 40001;
    localparam int OUT_IMG_LAST = 44096;
    localparam int STAT_IMG_FIRST = 45392;
    localparam int STAT_IMG_LAST = 49487;

    // count scale
    localparam logic signed [15:0] CNT_MIN = 16'shfc18;
    localparam logic signed [15:0] CNT_4MA = 16'sh0000;
    localparam logic signed [15:0] CNT_20MA = 16'sh7d00;
    localparam logic signed [15:0] CNT_MAX = 16'sh7fff;
    localparam int COUNTS_PER_MA = 2000;
    localparam int MA_OFFSET = 4;
    localparam int UA_PER_MA = 1000;

    // status word bit positions
    localparam int BIT_SUMMARY = 0;
    localparam int BIT_OVR_WARN = 2;
    localparam int BIT_OVR_ERR = 3;
    localparam int BIT_UNR_WARN = 4;
    localparam int BIT_UNR_ERR = 5;
    localparam int BIT_HW_FAULT = 6;

    // reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic signed [15:0] CMD_RESET = 16'sh0000;
    localparam logic [15:0] UA_RESET = 16'h0fa0;
    localparam logic signed [15:0] FALLBACK_DEFAULT = CNT_4MA;

endpackage : cod_pkg

// ### verilog/cod_range.sv
// Purpose: range flags and ideal current of one output count
// Assumes: count is a signed two's complement word
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module cod_range (
    // count in
    input wire logic signed [15:0] count,
    // range flags
    output logic over_range_warning,
    output logic over_range_error,
    output logic under_range_warning,
    output logic under_range_error,
    // ideal current in microamperes
    output logic [15:0] current_ua
);

    logic signed [31:0] ua_full;

    always_comb begin
        over_range_warning = (count > cod_pkg::CNT_20MA); // R11
        over_range_error = (count == cod_pkg::CNT_MAX); // R12
        under_range_warning = (count < cod_pkg::CNT_4MA); // R13
        under_range_error = (count <= cod_pkg::CNT_MIN); // R14
        // milliamperes = count / 2000 + 4, expressed in microamperes
        ua_full = (32'(count) * cod_pkg::UA_PER_MA)
            / cod_pkg::COUNTS_PER_MA
            + cod_pkg::MA_OFFSET * cod_pkg::UA_PER_MA; // R6
        current_ua = ua_full[15:0];
    end

endmodule : cod_range

`default_nettype wire

// ### verilog/cod_current_output.sv
// Purpose: output word, range status and fallback of one current output
// Assumes: island bus writes are synchronous to REF_CLK
// Notes: analog stage takes DAC_COUNT; CURRENT_UA is the ideal value
//
// Behaviour
// [R1] gateway holds 4096-word output image
// [R2] one output word, slot set by address
// [R3] bit 15 is sign, 15 magnitude bits
// [R4] all 16 bits valid, -1000 to 32767
// [R5] count 0 is 4 mA, 32000 is 20 mA
// [R6] current equals count over 2000 plus four
// [R7] flags judged from count, not current
// [R8] gateway holds 4096-word status image
// [R9] status bits above bit 6 read zero
// [R10] summary flag follows hardware fault only
// [R11] over-range warning above 32000
// [R12] over-range error at 32767
// [R13] under-range warning below zero
// [R14] under-range error at or below -1000
// [R15] hardware fault on broken wire or unpowered
// [R16] range flags never set summary flag
// [R17] disabled: minimum current, ignore writes, zero status
// [R18] comm lost: hold last or predefined value
// [R19] flags recomputed from each new command
`timescale 1ns/1ps
`default_nettype none

module cod_current_output #(
    parameter logic [11:0] NODE_ADDR = 12'h000
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // island bus write of the output image
    input wire logic WR_EN,
    input wire logic [11:0] WR_ADDR,
    input wire logic [15:0] WR_DATA,
    // configuration
    input wire logic CH_ENABLE,
    input wire logic FALLBACK_HOLD,
    input wire logic [15:0] FALLBACK_VALUE,
    // link and field state
    input wire logic COMM_LOST,
    input wire logic WIRE_BROKEN,
    input wire logic CH_UNPOWERED,
    // analog stage
    output logic [15:0] DAC_COUNT,
    output logic [15:0] CURRENT_UA,
    // status image word
    output logic [15:0] STATUS_WORD
);

    typedef enum logic [1:0] {
        COD_NORMAL = 2'b00,
        COD_FALLBACK = 2'b01,
        COD_DISABLED = 2'b10
    } cod_mode_t;

    typedef struct packed {
        cod_mode_t mode;
        logic signed [15:0] cmd;
        logic signed [15:0] out;
        logic [15:0] ua;
        logic [15:0] status;
    } cod_state_t;

    cod_state_t st_q;
    cod_state_t st_d;

    logic wr_hit;
    logic cmd_ovr_warn;
    logic cmd_ovr_err;
    logic cmd_unr_warn;
    logic cmd_unr_err;
    logic [15:0] out_ua;
    logic hw_fault;

    // next values of the state fields
    cod_mode_t mode_nxt;
    logic signed [15:0] cmd_nxt;
    logic signed [15:0] out_nxt;

    // mode of the coming cycle; disable outranks a lost link
    function automatic cod_mode_t next_mode(
        input logic enable,
        input logic lost
    );
        cod_mode_t m;
        if (!enable) begin
            m = COD_DISABLED;
        end else if (lost) begin
            m = COD_FALLBACK;
        end else begin
            m = COD_NORMAL;
        end
        return m;
    endfunction : next_mode

    // a taken write replaces the stored command
    function automatic logic signed [15:0] next_command(
        input logic take,
        input logic [15:0] word,
        input logic signed [15:0] stored
    );
        logic signed [15:0] c;
        c = stored;
        if (take) begin
            c = $signed(word); // R3 R4
        end
        return c;
    endfunction : next_command

    // count applied to the analog stage in a given mode
    function automatic logic signed [15:0] applied_count(
        input cod_mode_t m,
        input logic hold,
        input logic [15:0] predefined,
        input logic signed [15:0] last,
        input logic signed [15:0] cmd
    );
        logic signed [15:0] c;
        unique case (m)
            COD_NORMAL: begin
                c = cmd; // R5
            end
            COD_FALLBACK: begin
                // hold keeps the analog stage where the link left it
                if (hold) begin
                    c = last; // R18
                end else begin
                    c = $signed(predefined); // R18
                end
            end
            // a disabled channel sits at minimum current
            COD_DISABLED: begin
                c = cod_pkg::CNT_MIN; // R17
            end
            default: begin
                c = cod_pkg::CNT_MIN;
            end
        endcase
        return c;
    endfunction : applied_count

    // status word; range flags judge the command, never the current
    function automatic logic [15:0] status_of(
        input logic enabled,
        input logic ovr_warn,
        input logic ovr_err,
        input logic unr_warn,
        input logic unr_err,
        input logic fault
    );
        logic [15:0] s;
        s = cod_pkg::STATUS_RESET; // R9
        if (enabled) begin
            s[cod_pkg::BIT_OVR_WARN] = ovr_warn; // R7 R19
            s[cod_pkg::BIT_OVR_ERR] = ovr_err; // R7 R19
            s[cod_pkg::BIT_UNR_WARN] = unr_warn; // R7 R19
            s[cod_pkg::BIT_UNR_ERR] = unr_err; // R7 R19
            s[cod_pkg::BIT_HW_FAULT] = fault; // R15
            // only the hardware fault reaches the summary bit
            s[cod_pkg::BIT_SUMMARY] = fault; // R10 R16
        end
        return s;
    endfunction : status_of

    // one image word belongs to this module
    assign wr_hit = WR_EN && (WR_ADDR == NODE_ADDR); // R2
    assign hw_fault = WIRE_BROKEN | CH_UNPOWERED; // R15
    // writes are dropped while the channel is off
    assign mode_nxt = next_mode(CH_ENABLE, COMM_LOST);
    assign cmd_nxt = next_command(wr_hit && CH_ENABLE, WR_DATA,
        st_q.cmd); // R17
    assign out_nxt = applied_count(mode_nxt, FALLBACK_HOLD, FALLBACK_VALUE,
        st_q.out, cmd_nxt);

    // flags from the written count
    cod_range u_cmd_range (
        .count(cmd_nxt),
        .over_range_warning(cmd_ovr_warn),
        .over_range_error(cmd_ovr_err),
        .under_range_warning(cmd_unr_warn),
        .under_range_error(cmd_unr_err),
        .current_ua()
    );

    // ideal current of the applied count
    cod_range u_out_range (
        .count(out_nxt),
        .over_range_warning(),
        .over_range_error(),
        .under_range_warning(),
        .under_range_error(),
        .current_ua(out_ua)
    );

    always_comb begin
        st_d = st_q;
        st_d.mode = mode_nxt;
        st_d.cmd = cmd_nxt;
        st_d.out = out_nxt;
        st_d.ua = out_ua; // R6
        // status from the latest command count
        st_d.status = status_of(mode_nxt != COD_DISABLED, cmd_ovr_warn,
            cmd_ovr_err, cmd_unr_warn, cmd_unr_err, hw_fault);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q.mode <= COD_NORMAL;
            st_q.cmd <= cod_pkg::CMD_RESET;
            st_q.out <= cod_pkg::FALLBACK_DEFAULT;
            st_q.ua <= cod_pkg::UA_RESET;
            st_q.status <= cod_pkg::STATUS_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign DAC_COUNT = st_q.out;
    assign CURRENT_UA = st_q.ua;
    assign STATUS_WORD = st_q.status;

endmodule : cod_current_output

`default_nettype wire

// ### tb/cod_gateway_model.sv
// Purpose: island gateway writing the output image
// Assumes: writes launched on a rising edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cod_gateway_model #(
    parameter logic [11:0] NODE = 12'h000
) (
    input wire logic clk,
    input wire logic [15:0] stat,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [15:0] wr_data
);
    logic [15:0] img [4096];
    logic [15:0] stat_img [4096];
    // status image refreshed mid-cycle, once the word has settled
    always @(negedge clk) begin
        stat_img[NODE] <= stat;
    end
    initial begin
        wr_en = 1'b0;
        wr_addr = 12'hfff;
        wr_data = 16'h0000;
    end
    task automatic put(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        img[a] = d;
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask : put
endmodule : cod_gateway_model
`default_nettype wire

// ### tb/cod_checker.sv
// Purpose: port checks of the current output block
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module cod_checker #(
    parameter logic [11:0] NODE_ADDR = 12'h000
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // island bus write
    input wire logic WR_EN,
    input wire logic [11:0] WR_ADDR,
    input wire logic [15:0] WR_DATA,
    // configuration and field state
    input wire logic CH_ENABLE,
    input wire logic FALLBACK_HOLD,
    input wire logic [15:0] FALLBACK_VALUE,
    input wire logic COMM_LOST,
    input wire logic WIRE_BROKEN,
    input wire logic CH_UNPOWERED,
    // outputs under watch
    input wire logic [15:0] DAC_COUNT,
    input wire logic [15:0] CURRENT_UA,
    input wire logic [15:0] STATUS_WORD
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic signed [15:0] d_q;
    logic wr, hold;
    assign wr = WR_EN && WR_ADDR == NODE_ADDR && CH_ENABLE;
    assign hold = COMM_LOST && CH_ENABLE && FALLBACK_HOLD;
    always_ff @(posedge REF_CLK) d_q <= WR_DATA;
    a_spare_zero: assert property (
        STATUS_WORD[15:7] == 9'h000 && !STATUS_WORD[1]) else $error("spare");
    a_summary_hw: assert property (
        STATUS_WORD[0] == STATUS_WORD[6]) else $error("summary");
    a_hw_fault: assert property (CH_ENABLE |=>
        STATUS_WORD[6] == $past(WIRE_BROKEN || CH_UNPOWERED)) else $error("hw");
    a_ovr_warn: assert property (
        wr |=> STATUS_WORD[2] == (d_q > 16'sh7d00)) else $error("ovr warn");
    a_ovr_err: assert property (
        wr |=> STATUS_WORD[3] == (d_q == 16'sh7fff)) else $error("ovr err");
    a_unr_warn: assert property (
        wr |=> STATUS_WORD[4] == d_q[15]) else $error("unr warn");
    a_unr_err: assert property (
        wr |=> STATUS_WORD[5] == (d_q <= 16'shfc18)) else $error("unr err");
    a_off_zero: assert property (!CH_ENABLE |=>
        STATUS_WORD == 16'h0000 && DAC_COUNT == 16'hfc18) else $error("off");
    a_new_count: assert property (wr && !COMM_LOST |=> DAC_COUNT == d_q &&
        CURRENT_UA == $unsigned(d_q / 16'sh0002 + 16'sh0fa0)) else $error("cnt");
    a_fb_value: assert property (COMM_LOST && CH_ENABLE && !FALLBACK_HOLD
        |=> DAC_COUNT == $past(FALLBACK_VALUE)) else $error("fallback");
    a_fb_hold: assert property (
        hold [*2] |-> $stable(DAC_COUNT)) else $error("hold");
    c_write: cover property (wr && !COMM_LOST);
    c_fault: cover property (STATUS_WORD[0]);
    c_hold: cover property (hold [*2]);
    c_fb_value: cover property (COMM_LOST && CH_ENABLE && !FALLBACK_HOLD);
endmodule : cod_checker
bind cod_current_output cod_checker #(.NODE_ADDR(NODE_ADDR)) u_chk (
    .REF_CLK, .RST_N, .WR_EN, .WR_ADDR, .WR_DATA, .CH_ENABLE, .FALLBACK_HOLD,
    .FALLBACK_VALUE, .COMM_LOST, .WIRE_BROKEN, .CH_UNPOWERED, .DAC_COUNT,
    .CURRENT_UA, .STATUS_WORD);
`default_nettype wire

// ### tb/tb_current_output_data_status.sv
// Purpose: bench of the current output block
// Assumes: gateway model issues the writes
// Notes: expectations come from the count rules
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_current_output_data_status;
    localparam logic [11:0] SLOT = 12'h005;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, fb_hold = 1'b0;
    logic lost = 1'b0, brk = 1'b0, unpw = 1'b0, wr_en;
    logic [11:0] wr_addr;
    logic [15:0] wr_data, fb_val = 16'h0000, dac, cur, stat;
    logic signed [15:0] cnt [8] = '{16'shfc18, 16'shfc19, 16'shffff,
        16'sh0000, 16'sh7d00, 16'sh7d01, 16'sh7ffe, 16'sh7fff};
    int fails = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    cod_gateway_model #(.NODE(SLOT)) gw (.clk(clk), .stat(stat),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    cod_current_output #(.NODE_ADDR(SLOT)) dut (.REF_CLK(clk), .RST_N(rst_n),
        .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .CH_ENABLE(en),
        .FALLBACK_HOLD(fb_hold), .FALLBACK_VALUE(fb_val), .COMM_LOST(lost),
        .WIRE_BROKEN(brk), .CH_UNPOWERED(unpw), .DAC_COUNT(dac),
        .CURRENT_UA(cur), .STATUS_WORD(stat));
    function automatic logic [15:0] exp_st(logic signed [15:0] c, logic hw);
        return {9'h000, hw, c <= 16'shfc18, c[15], c == 16'sh7fff,
            c > 16'sh7d00, 1'b0, hw};
    endfunction : exp_st
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CMP(stat, 16'h0000)
        `CMP(cur, 16'h0fa0)
        foreach (cnt[i]) begin
            gw.put(SLOT, cnt[i]);
            #1;
            `CMP(stat, exp_st(cnt[i], 1'b0))
            `CMP(cur, $unsigned(cnt[i] / 16'sh0002 + 16'sh0fa0))
            `CMP(dac, cnt[i])
        end
        gw.put(SLOT + 12'h001, 16'h1234);
        #1;
        `CMP(dac, 16'h7fff)
        `CMP(gw.img[SLOT], 16'h7fff)
        `CMP(gw.stat_img[SLOT], exp_st(16'sh7fff, 1'b0))
        $display("range test done");
        @(posedge clk) brk <= 1'b1;
        tick();
        `CMP(stat, exp_st(16'sh7fff, 1'b1))
        @(posedge clk) begin
            brk <= 1'b0;
            unpw <= 1'b1;
            en <= 1'b0;
        end
        tick();
        gw.put(SLOT, 16'h0100);
        #1;
        `CMP(stat, 16'h0000)
        `CMP(dac, 16'hfc18)
        @(posedge clk) en <= 1'b1;
        tick();
        `CMP(stat, exp_st(16'sh7fff, 1'b1))
        `CMP(dac, 16'h7fff)
        @(posedge clk) begin
            lost <= 1'b1;
            fb_hold <= 1'b1;
        end
        tick();
        `CMP(dac, 16'h7fff)
        gw.put(SLOT, 16'hff00);
        #1;
        `CMP(dac, 16'h7fff)
        `CMP(stat, exp_st(16'shff00, 1'b1))
        @(posedge clk) begin
            fb_hold <= 1'b0;
            fb_val <= 16'h1f40;
        end
        tick();
        `CMP(dac, 16'h1f40)
        @(posedge clk) lost <= 1'b0;
        tick();
        `CMP(dac, 16'hff00)
        `CMP(cur, 16'h0f20)
        $display("fault and fallback test done");
        test_done();
    end
endmodule : tb_current_output_data_status
`default_nettype wire
